// File: verilog/vsp_defs.svh
// Constants for the volatile sector protection command host.
// Behaviour
// [R1] A read at any address in protection mode leaves the device there and returns protection info.
// [R2] Writing 70h at 555h enters status read; the next read returns status and goes back.
// [R3] Writing 71h at 555h clears the status register and the device stays in protection mode.
// [R4] Writing F0h at any address is a software reset back to normal array read.
// [R5] Writing 90h at any address enters the exit sub-state that waits for the confirm write.
// [R6] Writing A0h at any address enters the set/clear sub-state awaiting a sector write.
// [R7] In set/clear, 00h at a sector address sets that sector's volatile bit and returns.
// [R8] In set/clear, 01h at a sector address clears that sector's volatile bit and returns.
// [R9] In the exit sub-state, 00h at any address returns the device to normal array read.
// [R10] A command write not valid for the current sub-state is ignored by the device.
`ifndef VSP_DEFS_SVH
`define VSP_DEFS_SVH

// -----------------------------------------------------------------------------
// Bus widths.
// -----------------------------------------------------------------------------
`define VSP_ADDR_W 24
`define VSP_DATA_W 16

// -----------------------------------------------------------------------------
// Command addresses and data.
// -----------------------------------------------------------------------------
`define VSP_ADDR_CMD   24'h000555
`define VSP_ADDR_ANY   24'h000000
`define VSP_D_SR_READ  16'h0070
`define VSP_D_SR_CLEAR 16'h0071
`define VSP_D_RESET    16'h00f0
`define VSP_D_EXIT     16'h0090
`define VSP_D_SETCLR   16'h00a0
`define VSP_D_SET      16'h0000
`define VSP_D_CLEAR    16'h0001
`define VSP_D_EXIT_OK  16'h0000

// -----------------------------------------------------------------------------
// Timing.
// -----------------------------------------------------------------------------
`define VSP_CLK_NS     100
`define VSP_T_WP_NS    50
`define VSP_T_RD_NS    100
`define VSP_CYC_UP(t)  (((t) + `VSP_CLK_NS - 1) / `VSP_CLK_NS)
`define VSP_WP_CYC     `VSP_CYC_UP(`VSP_T_WP_NS)
`define VSP_RD_CYC     `VSP_CYC_UP(`VSP_T_RD_NS)
`define VSP_CNT_W      4

`endif

// File: verilog/vsp_pkg.sv
// Types shared by the volatile sector protection command host.
`include "vsp_defs.svh"
package vsp_pkg;

  typedef enum logic [2:0] {
    VSP_CMD_READ_PROT = 3'h0,
    VSP_CMD_SR_READ   = 3'h1,
    VSP_CMD_SR_CLEAR  = 3'h2,
    VSP_CMD_RESET     = 3'h3,
    VSP_CMD_SET       = 3'h4,
    VSP_CMD_CLEAR     = 3'h5,
    VSP_CMD_EXIT      = 3'h6
  } vsp_cmd_t;

  typedef struct packed {
    logic                   write;
    logic [`VSP_ADDR_W-1:0] addr;
    logic [`VSP_DATA_W-1:0] data;
  } vsp_req_t;

  typedef struct packed {
    logic                   ce_n;
    logic                   we_n;
    logic                   oe_n;
    logic [`VSP_ADDR_W-1:0] addr;
    logic [`VSP_DATA_W-1:0] dq_o;
    logic                   dq_oe;
  } vsp_pins_t;

endpackage

// File: verilog/vsp_bus_cycle.sv
// One asynchronous write or read cycle on the flash pins.
`timescale 1ns/1ps
`include "vsp_defs.svh"
module vsp_bus_cycle (
  // Clock and reset.
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  // Request.
  input  wire logic                   i_start,
  input  wire vsp_pkg::vsp_req_t      i_req,
  output logic                        o_done,
  output logic [`VSP_DATA_W-1:0]      o_rdata,
  // Flash pins.
  input  wire logic [`VSP_DATA_W-1:0] i_dq,
  output vsp_pkg::vsp_pins_t          o_pins
);
  import vsp_pkg::*;

  typedef enum logic [3:0] {
    B_IDLE   = 4'b0001,
    B_SETUP  = 4'b0010,
    B_STROBE = 4'b0100,
    B_HOLD   = 4'b1000
  } vsp_bstate_t;

  vsp_bstate_t             state_reg, state_next;
  logic [`VSP_CNT_W-1:0]   cnt_reg, cnt_next;
  vsp_pins_t               pins_reg, pins_next;
  logic                    done_reg, done_next;
  logic [`VSP_DATA_W-1:0]  rdata_reg, rdata_next;

  localparam vsp_pins_t PINS_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                      addr: '0, dq_o: '0, dq_oe: 1'b0};

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    pins_next  = pins_reg;
    done_next  = 1'b0;
    rdata_next = rdata_reg;
    case (state_reg)
      B_IDLE: begin
        if (i_start) begin
          pins_next.ce_n  = 1'b0;
          pins_next.addr  = i_req.addr;
          pins_next.dq_o  = i_req.data;
          pins_next.dq_oe = i_req.write;
          state_next      = B_SETUP;
        end
      end
      B_SETUP: begin
        if (pins_reg.dq_oe) begin
          pins_next.we_n = 1'b0;
          cnt_next       = `VSP_CNT_W'(`VSP_WP_CYC - 1);
        end else begin
          pins_next.oe_n = 1'b0;
          cnt_next       = `VSP_CNT_W'(`VSP_RD_CYC - 1);
        end
        state_next = B_STROBE;
      end
      B_STROBE: begin
        if (cnt_reg == '0) begin
          pins_next.we_n = 1'b1;
          pins_next.oe_n = 1'b1;
          if (!pins_reg.dq_oe) begin
            rdata_next = i_dq;
          end
          state_next = B_HOLD;
        end else begin
          cnt_next = cnt_reg - `VSP_CNT_W'(1);
        end
      end
      B_HOLD: begin
        pins_next  = PINS_IDLE;
        done_next  = 1'b1;
        state_next = B_IDLE;
      end
      default: begin
        pins_next  = PINS_IDLE;
        state_next = B_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= B_IDLE;
      cnt_reg   <= '0;
      pins_reg  <= PINS_IDLE;
      done_reg  <= 1'b0;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      pins_reg  <= pins_next;
      done_reg  <= done_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_pins  = pins_reg;
  assign o_done  = done_reg;
  assign o_rdata = rdata_reg;

endmodule // vsp_bus_cycle

// File: verilog/vsp_host.sv
// Host sequencer that issues volatile sector protection command cycles.
`timescale 1ns/1ps
`include "vsp_defs.svh"
module vsp_host (
  // Clock and reset.
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  // User command port.
  input  wire logic                   i_cmd_valid,
  input  wire vsp_pkg::vsp_cmd_t      i_cmd,
  input  wire logic [`VSP_ADDR_W-1:0] i_addr,
  input  wire logic                   i_mode_entered,
  output logic                        o_ready,
  output logic                        o_done,
  output logic                        o_refused,
  output logic [`VSP_DATA_W-1:0]      o_rdata,
  output logic                        o_mode,
  // Flash pins.
  input  wire logic [`VSP_DATA_W-1:0] i_dq,
  output vsp_pkg::vsp_pins_t          o_pins
);
  import vsp_pkg::*;

  typedef enum logic [2:0] {
    M_IDLE   = 3'b001,
    M_FIRST  = 3'b010,
    M_SECOND = 3'b100
  } vsp_mstate_t;

  // ---------------------------------------------------------------------------
  // Command cycle tables.
  // ---------------------------------------------------------------------------
  function automatic logic two_cycle(input vsp_cmd_t c);
    two_cycle = (c == VSP_CMD_SR_READ) || (c == VSP_CMD_SET) ||
                (c == VSP_CMD_CLEAR) || (c == VSP_CMD_EXIT);
  endfunction

  function automatic vsp_req_t first_cycle(input vsp_cmd_t c,
                                           input logic [`VSP_ADDR_W-1:0] a);
    first_cycle = '{write: 1'b1, addr: `VSP_ADDR_ANY, data: `VSP_D_RESET};
    case (c)
      VSP_CMD_READ_PROT: first_cycle = '{write: 1'b0, addr: a, data: '0};        // [R1]
      VSP_CMD_SR_READ:   first_cycle.addr = `VSP_ADDR_CMD;                        // [R2]
      VSP_CMD_SR_CLEAR:  first_cycle.addr = `VSP_ADDR_CMD;                        // [R3]
      default:           first_cycle.addr = `VSP_ADDR_ANY;
    endcase
    case (c)
      VSP_CMD_SR_READ:  first_cycle.data = `VSP_D_SR_READ;                        // [R2]
      VSP_CMD_SR_CLEAR: first_cycle.data = `VSP_D_SR_CLEAR;                       // [R3]
      VSP_CMD_SET,
      VSP_CMD_CLEAR:    first_cycle.data = `VSP_D_SETCLR;                         // [R6]
      VSP_CMD_EXIT:     first_cycle.data = `VSP_D_EXIT;                           // [R5]
      VSP_CMD_RESET:    first_cycle.data = `VSP_D_RESET;                          // [R4]
      default:          first_cycle.data = first_cycle.data;
    endcase
  endfunction

  function automatic vsp_req_t second_cycle(input vsp_cmd_t c,
                                            input logic [`VSP_ADDR_W-1:0] a);
    case (c)
      VSP_CMD_SR_READ: second_cycle = '{write: 1'b0, addr: a, data: '0};         // [R2]
      VSP_CMD_SET:     second_cycle = '{write: 1'b1, addr: a, data: `VSP_D_SET};  // [R7]
      VSP_CMD_CLEAR:   second_cycle = '{write: 1'b1, addr: a, data: `VSP_D_CLEAR}; // [R8]
      default:         second_cycle = '{write: 1'b1, addr: `VSP_ADDR_ANY,
                                        data: `VSP_D_EXIT_OK};                    // [R9]
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Sequencer.
  // ---------------------------------------------------------------------------
  vsp_mstate_t             state_reg, state_next;
  vsp_cmd_t                cmd_reg, cmd_next;
  logic [`VSP_ADDR_W-1:0]  addr_reg, addr_next;
  vsp_req_t                req_reg, req_next;
  logic                    start_reg, start_next;
  logic                    mode_reg, mode_next;
  logic                    ready_reg, ready_next;
  logic                    done_reg, done_next;
  logic                    refused_reg, refused_next;
  logic [`VSP_DATA_W-1:0]  rdata_reg, rdata_next;
  logic                    bus_done;
  logic [`VSP_DATA_W-1:0]  bus_rdata;
  logic                    allowed;
  logic                    accept;

  // Outside protection mode only the reset is safe to send.
  assign allowed = mode_reg || (i_cmd == VSP_CMD_RESET);                          // [R10]
  assign accept  = (state_reg == M_IDLE) && i_cmd_valid && allowed;

  always_comb begin
    state_next   = state_reg;
    cmd_next     = cmd_reg;
    addr_next    = addr_reg;
    req_next     = req_reg;
    start_next   = 1'b0;
    mode_next    = mode_reg;
    done_next    = 1'b0;
    refused_next = 1'b0;
    rdata_next   = rdata_reg;
    case (state_reg)
      M_IDLE: begin
        if (i_mode_entered) begin
          mode_next = 1'b1;
        end
        if (accept) begin
          cmd_next   = i_cmd;
          addr_next  = i_addr;
          req_next   = first_cycle(i_cmd, i_addr);
          start_next = 1'b1;
          state_next = M_FIRST;
        end else if (i_cmd_valid) begin
          refused_next = 1'b1;                                                    // [R10]
        end
      end
      M_FIRST: begin
        if (bus_done) begin
          rdata_next = bus_rdata;                                                 // [R1]
          if (two_cycle(cmd_reg)) begin
            req_next   = second_cycle(cmd_reg, addr_reg);
            start_next = 1'b1;
            state_next = M_SECOND;
          end else begin
            done_next  = 1'b1;
            state_next = M_IDLE;
            if (cmd_reg == VSP_CMD_RESET) begin
              mode_next = 1'b0;                                                   // [R4]
            end
          end
        end
      end
      M_SECOND: begin
        if (bus_done) begin
          rdata_next = bus_rdata;                                                 // [R2]
          done_next  = 1'b1;
          state_next = M_IDLE;
          if (cmd_reg == VSP_CMD_EXIT) begin
            mode_next = 1'b0;                                                     // [R9]
          end
        end
      end
      default: begin
        state_next = M_IDLE;
      end
    endcase
    ready_next = (state_next == M_IDLE);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg   <= M_IDLE;
      cmd_reg     <= VSP_CMD_READ_PROT;
      addr_reg    <= '0;
      req_reg     <= '0;
      start_reg   <= 1'b0;
      mode_reg    <= 1'b0;
      ready_reg   <= 1'b0;
      done_reg    <= 1'b0;
      refused_reg <= 1'b0;
      rdata_reg   <= '0;
    end else begin
      state_reg   <= state_next;
      cmd_reg     <= cmd_next;
      addr_reg    <= addr_next;
      req_reg     <= req_next;
      start_reg   <= start_next;
      mode_reg    <= mode_next;
      ready_reg   <= ready_next;
      done_reg    <= done_next;
      refused_reg <= refused_next;
      rdata_reg   <= rdata_next;
    end
  end

  vsp_bus_cycle u_bus (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_start (start_reg),
    .i_req   (req_reg),
    .o_done  (bus_done),
    .o_rdata (bus_rdata),
    .i_dq    (i_dq),
    .o_pins  (o_pins)
  );

  assign o_ready   = ready_reg;
  assign o_done    = done_reg;
  assign o_refused = refused_reg;
  assign o_rdata   = rdata_reg;
  assign o_mode    = mode_reg;

  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------
  property p_read_prot;
    @(posedge i_clk) disable iff (i_rst)
    accept && (i_cmd == VSP_CMD_READ_PROT) |=> start_reg && !req_reg.write && mode_reg
      ##5 !start_reg && mode_reg;
  endproperty
  a_read_prot: assert property (p_read_prot) else $error("protection read misissued"); // [R1]

  property p_sr_read;
    @(posedge i_clk) disable iff (i_rst)
    start_reg && req_reg.write && (req_reg.data == `VSP_D_SR_READ) && (cmd_reg == VSP_CMD_SR_READ)
      |-> (req_reg.addr == `VSP_ADDR_CMD) ##5 (start_reg && !req_reg.write);
  endproperty
  a_sr_read: assert property (p_sr_read) else $error("status read not followed by read"); // [R2]

  property p_sr_clear;
    @(posedge i_clk) disable iff (i_rst)
    accept && (i_cmd == VSP_CMD_SR_CLEAR) |=> start_reg && req_reg.write &&
      (req_reg.addr == `VSP_ADDR_CMD) && (req_reg.data == `VSP_D_SR_CLEAR)
      ##5 done_reg && mode_reg;
  endproperty
  a_sr_clear: assert property (p_sr_clear) else $error("status clear misissued"); // [R3]

  property p_reset;
    @(posedge i_clk) disable iff (i_rst)
    accept && (i_cmd == VSP_CMD_RESET) |=> (start_reg && (req_reg.data == `VSP_D_RESET))
      ##5 (done_reg && !mode_reg);
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not leave protection mode"); // [R4]

  property p_exit_entry;
    @(posedge i_clk) disable iff (i_rst)
    accept && (i_cmd == VSP_CMD_EXIT) |=> start_reg && req_reg.write &&
      (req_reg.data == `VSP_D_EXIT);
  endproperty
  a_exit_entry: assert property (p_exit_entry) else $error("exit entry misissued"); // [R5]

  property p_setclr_entry;
    @(posedge i_clk) disable iff (i_rst)
    accept && ((i_cmd == VSP_CMD_SET) || (i_cmd == VSP_CMD_CLEAR))
      |=> start_reg && req_reg.write && (req_reg.data == `VSP_D_SETCLR);
  endproperty
  a_setclr_entry: assert property (p_setclr_entry) else $error("set/clear entry misissued"); // [R6]

  property p_set_sector;
    @(posedge i_clk) disable iff (i_rst)
    start_reg && (state_reg == M_FIRST) && (cmd_reg == VSP_CMD_SET) |-> ##5
      (start_reg && (req_reg.addr == addr_reg) && (req_reg.data == `VSP_D_SET));
  endproperty
  a_set_sector: assert property (p_set_sector) else $error("sector set write wrong"); // [R7]

  property p_clear_sector;
    @(posedge i_clk) disable iff (i_rst)
    start_reg && (state_reg == M_FIRST) && (cmd_reg == VSP_CMD_CLEAR) |-> ##5
      (start_reg && (req_reg.addr == addr_reg) && (req_reg.data == `VSP_D_CLEAR));
  endproperty
  a_clear_sector: assert property (p_clear_sector) else $error("sector clear write wrong"); // [R8]

  property p_exit_confirm;
    @(posedge i_clk) disable iff (i_rst)
    start_reg && (req_reg.data == `VSP_D_EXIT) && (cmd_reg == VSP_CMD_EXIT) |-> ##5
      (start_reg && req_reg.write && (req_reg.data == `VSP_D_EXIT_OK)) ##5 !mode_reg;
  endproperty
  a_exit_confirm: assert property (p_exit_confirm) else $error("exit confirm missing"); // [R9]

  property p_refuse;
    @(posedge i_clk) disable iff (i_rst)
    (state_reg == M_IDLE) && i_cmd_valid && !mode_reg && (i_cmd != VSP_CMD_RESET)
      |=> refused_reg && !start_reg && (state_reg == M_IDLE);
  endproperty
  a_refuse: assert property (p_refuse) else $error("invalid command was issued"); // [R10]

endmodule // vsp_host

// File: tb/vsp_flash_model.sv
// Behavioural model of the flash volatile protection command logic.
`timescale 1ns/1ps
`include "vsp_defs.svh"
module vsp_flash_model (
  // Clock and reset.
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  // Mode entry made by the bench.
  input  wire logic                   i_enter,
  // Flash pins.
  input  wire vsp_pkg::vsp_pins_t     i_pins,
  output logic [`VSP_DATA_W-1:0]      o_dq,
  // Observation.
  output logic                        o_in_mode,
  output logic [3:0]                  o_prot
);
  import vsp_pkg::*;
  typedef enum logic [2:0] {
    VSP_DEV_READ, VSP_DEV_MODE, VSP_DEV_SR, VSP_DEV_SETCLR, VSP_DEV_EXIT
  } vsp_dev_t;
  vsp_dev_t               state_reg;
  logic                   we_n_reg;
  logic                   oe_n_reg;
  logic [`VSP_DATA_W-1:0] sr_reg;
  logic [`VSP_DATA_W-1:0] last_reg;
  logic [`VSP_DATA_W-1:0] rd;
  logic [`VSP_DATA_W-1:0] wd;
  logic [1:0]             sect;
  logic                   wr_ev;
  assign sect      = i_pins.addr[17:16];
  assign wd        = i_pins.dq_o;
  assign o_in_mode = (state_reg != VSP_DEV_READ);
  assign wr_ev     = !i_pins.ce_n && !we_n_reg && i_pins.we_n;
  // A released bus shows the inverse of its last value, so stale data never matches.
  always_comb begin
    case (state_reg)
      VSP_DEV_READ: rd = i_pins.addr[15:0] ^ 16'h5a5a;
      VSP_DEV_SR:   rd = sr_reg;
      default:      rd = {15'h0000, o_prot[sect]};
    endcase
    o_dq = (!i_pins.ce_n && !i_pins.oe_n) ? rd : ~last_reg;
  end
  always_ff @(posedge i_clk) begin
    we_n_reg <= i_pins.we_n;
    oe_n_reg <= i_pins.oe_n;
    last_reg <= o_dq;
    if (i_rst) begin
      state_reg <= VSP_DEV_READ;
      sr_reg    <= 16'h0080;
      o_prot    <= 4'h0;
      last_reg  <= 16'h0000;
    end else if (i_enter) begin
      state_reg <= VSP_DEV_MODE;
    end else if (wr_ev) begin
      case (state_reg)
        VSP_DEV_MODE: begin
          if (wd == 16'h00f0) state_reg <= VSP_DEV_READ;
          else if (wd == 16'h0070 && i_pins.addr == 24'h000555) state_reg <= VSP_DEV_SR;
          else if (wd == 16'h0071 && i_pins.addr == 24'h000555) sr_reg <= 16'h0080;
          else if (wd == 16'h0090) state_reg <= VSP_DEV_EXIT;
          else if (wd == 16'h00a0) state_reg <= VSP_DEV_SETCLR;
        end
        VSP_DEV_SETCLR: begin
          if (wd == 16'h0000 || wd == 16'h0001) begin
            o_prot[sect] <= (wd == 16'h0000);
            sr_reg       <= 16'h0081;
            state_reg    <= VSP_DEV_MODE;
          end
        end
        VSP_DEV_EXIT: if (wd == 16'h0000) state_reg <= VSP_DEV_READ;
        default: ;
      endcase
    end else if (!i_pins.ce_n && !oe_n_reg && i_pins.oe_n && state_reg == VSP_DEV_SR) begin
      state_reg <= VSP_DEV_MODE;
    end
  end
endmodule // vsp_flash_model

// File: tb/testbench.sv
// Self-checking bench for the volatile protection command host.
`timescale 1ns/1ps
`include "vsp_defs.svh"
module testbench;
  import vsp_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_cmd_valid = 1'b0;
  logic        i_mode_entered = 1'b0;
  vsp_cmd_t    i_cmd = VSP_CMD_READ_PROT;
  logic [23:0] i_addr = 24'h000000;
  logic        o_ready;
  logic        o_done;
  logic        o_refused;
  logic        o_mode;
  logic [15:0] o_rdata;
  logic [15:0] dq;
  vsp_pins_t   pins;
  logic        dev_mode;
  logic [3:0]  prot;
  int          errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  vsp_host dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .i_addr(i_addr), .i_mode_entered(i_mode_entered), .o_ready(o_ready),
    .o_done(o_done), .o_refused(o_refused), .o_rdata(o_rdata), .o_mode(o_mode),
    .i_dq(dq), .o_pins(pins)
  );
  vsp_flash_model flash_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_enter(i_mode_entered), .i_pins(pins),
    .o_dq(dq), .o_in_mode(dev_mode), .o_prot(prot)
  );
  always #50 i_clk = ~i_clk;
  // ---------------------------------------------------------------------------
  // Reporting.
  // ---------------------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  // Cuts a hang short well after the planned sequence should have ended.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      $display("mismatch at %0t: run did not finish", $time);
      wrap_up();
    end
  end
  // ---------------------------------------------------------------------------
  // Bus helpers.
  // ---------------------------------------------------------------------------
  task automatic run_cmd(input vsp_cmd_t cmd, input logic [23:0] addr, input int lat);
    int n;
    @(posedge i_clk);
    #1;
    i_cmd       = cmd;
    i_addr      = addr;
    i_cmd_valid = 1'b1;
    @(posedge i_clk);
    #1;
    i_cmd_valid = 1'b0;
    check_flag(o_ready, 1'b0, "busy after take");
    // The count includes the edge that samples o_done high.
    n = 1;
    while (o_done !== 1'b1 && n < 30) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check_val(n[15:0], lat[15:0], "command latency");
    check_flag(o_ready, 1'b1, "ready with done");
  endtask
  task automatic enter_mode;
    @(posedge i_clk);
    #1;
    i_mode_entered = 1'b1;
    @(posedge i_clk);
    #1;
    i_mode_entered = 1'b0;
  endtask
  task automatic read_prot(input logic [23:0] addr, input logic [15:0] exp);
    run_cmd(VSP_CMD_READ_PROT, addr, 6);
    check_val(o_rdata, exp, "read data");
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------------
  task automatic t_refused;
    @(posedge i_clk);
    #1;
    i_cmd       = VSP_CMD_SET;
    i_cmd_valid = 1'b1;
    @(posedge i_clk);
    #1;
    i_cmd_valid = 1'b0;
    check_flag(o_refused, 1'b1, "refused pulse");
    check_flag(o_ready, 1'b1, "ready kept on refusal");
    @(posedge i_clk);
    #1;
    check_flag(o_refused, 1'b0, "refused pulse ends");
    check_flag(pins.ce_n, 1'b1, "chip idle on refusal");
  endtask
  task automatic t_set_clear;
    enter_mode();
    read_prot(24'h010000, 16'h0000);
    run_cmd(VSP_CMD_SET, 24'h010000, 11);
    check_val({12'h000, prot}, 16'h0002, "bits after set");
    read_prot(24'h010000, 16'h0001);
    read_prot(24'h020000, 16'h0000);
    check_flag(dev_mode, 1'b1, "device in mode");
    run_cmd(VSP_CMD_CLEAR, 24'h010000, 11);
    read_prot(24'h010000, 16'h0000);
  endtask
  task automatic t_status;
    run_cmd(VSP_CMD_SR_READ, 24'h000000, 11);
    check_val(o_rdata, 16'h0081, "status after write");
    check_flag(dev_mode, 1'b1, "back in mode");
    read_prot(24'h030000, 16'h0000);
    run_cmd(VSP_CMD_SR_CLEAR, 24'h000000, 6);
    check_flag(dev_mode, 1'b1, "mode kept on clear");
    run_cmd(VSP_CMD_SR_READ, 24'h000000, 11);
    check_val(o_rdata, 16'h0080, "status after clear");
  endtask
  task automatic t_exit;
    run_cmd(VSP_CMD_EXIT, 24'h000000, 11);
    check_flag(dev_mode, 1'b0, "device left mode");
    check_flag(o_mode, 1'b0, "host left mode");
    t_refused();
  endtask
  task automatic t_reset;
    enter_mode();
    run_cmd(VSP_CMD_SET, 24'h030000, 11);
    run_cmd(VSP_CMD_RESET, 24'h000000, 6);
    check_flag(dev_mode, 1'b0, "device reset");
    check_flag(o_mode, 1'b0, "host reset");
    run_cmd(VSP_CMD_RESET, 24'h000000, 6);
    check_flag(dev_mode, 1'b0, "reset outside mode");
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    t_refused();
    t_set_clear();
    t_status();
    t_exit();
    t_reset();
    wrap_up();
  end
endmodule // testbench
